// [rtl/gpio_cfg_pkg.sv]
package gpio_cfg_pkg;

    // register command addresses
    localparam logic [7:0] ADDR_BUS_TIMEOUT_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_LED_MODE_SELECT    = 8'h31;
    localparam logic [7:0] ADDR_PORT_DIRECTION_LOW = 8'h34;
    localparam logic [7:0] ADDR_PORT_DIRECTION_HIGH = 8'h35;
    localparam logic [7:0] ADDR_DRIVE_TYPE_LOW     = 8'h36;
    localparam logic [7:0] ADDR_DRIVE_TYPE_HIGH    = 8'h37;
    localparam logic [7:0] ADDR_SUPPLY_SELECT_LOW  = 8'h38;
    localparam logic [7:0] ADDR_SUPPLY_SELECT_HIGH = 8'h39;

    // auto-increment window of the command pointer
    localparam logic [7:0] PTR_AUTOINC_FIRST = 8'h31;
    localparam logic [7:0] PTR_AUTOINC_LAST  = 8'h5B;

    // field layout and reset values
    localparam int          TIMEOUT_DISABLE_BIT   = 0;
    localparam logic [6:0]  CFG_RESERVED_VALUE    = 7'h05;
    localparam logic        TIMEOUT_DISABLE_RESET = 1'b0;
    localparam logic [3:0]  LED_MODE_RESET        = 4'h0;
    localparam logic [15:0] DIRECTION_RESET       = 16'h0000;
    localparam logic [11:0] DRIVE_TYPE_RESET      = 12'h000;
    localparam logic [15:0] SUPPLY_RESET          = 16'h0000;

    // bus timing
    localparam int CLK_PERIOD_NS      = 4;
    localparam int BUS_TIMEOUT_MS     = 20;
    localparam int BUS_TIMEOUT_CYCLES =
        (BUS_TIMEOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_CNT_W      = 25;

    // device address on the serial bus, arbitrary value
    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h20;

    typedef struct packed {
        logic        timeout_disable;
        logic [3:0]  led_mode;
        logic [15:0] direction;
        logic [11:0] drive_type;
        logic [15:0] supply;
    } cfg_regs_t;

    localparam cfg_regs_t REGS_RESET = '{
        timeout_disable: TIMEOUT_DISABLE_RESET,
        led_mode:        LED_MODE_RESET,
        direction:       DIRECTION_RESET,
        drive_type:      DRIVE_TYPE_RESET,
        supply:          SUPPLY_RESET
    };

    typedef struct packed {
        logic [15:0] output_dir;
        logic [15:0] push_pull;
        logic [15:0] alt_supply;
        logic [3:0]  led_sink_en;
    } port_ctrl_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_CMD,
        S_WDATA,
        S_ACK,
        S_RDATA,
        S_MACK
    } i2c_state_t;

endpackage

// [rtl/sync2.sv]
`timescale 1ns/1ps
module sync2 #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_reg <= RESET_VALUE;
            sync_reg <= RESET_VALUE;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule

// [rtl/gpio_port_config_registers.sv]
`timescale 1ns/1ps
module gpio_port_config_registers
    import gpio_cfg_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR     = SLAVE_ADDR_DEFAULT,
    parameter int         TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
    input  wire logic  i_clk_sys,
    input  wire logic  i_rstn,
    input  wire logic  i_scl,
    input  wire logic  i_sda,
    output logic       o_sda_out,
    output logic       o_sda_oe,
    output port_ctrl_t o_port_ctrl,
    output logic       o_timeout_disable
);
    localparam logic [TIMEOUT_CNT_W-1:0] TIMEOUT_LIMIT = TIMEOUT_CNT_W'(TIMEOUT_CYCLES);

    logic                     rst_sync_n;
    logic [1:0]               pins_raw;
    bus_pins_t                pins_sync;
    bus_pins_t                pins_prev_reg;
    logic                     scl_rise;
    logic                     scl_fall;
    logic                     start_seen;
    logic                     stop_seen;
    logic                     timed_out;
    logic [7:0]               rd_byte;

    i2c_state_t               state_reg;
    i2c_state_t               state_next;
    i2c_state_t               after_reg;
    i2c_state_t               after_next;
    logic [3:0]               bit_cnt_reg;
    logic [3:0]               bit_cnt_next;
    logic [7:0]               shift_reg;
    logic [7:0]               shift_next;
    logic [7:0]               ptr_reg;
    logic [7:0]               ptr_next;
    logic                     sda_oe_reg;
    logic                     sda_oe_next;
    logic [TIMEOUT_CNT_W-1:0] tmo_cnt_reg;
    logic [TIMEOUT_CNT_W-1:0] tmo_cnt_next;
    cfg_regs_t                regs_reg;
    cfg_regs_t                regs_next;

    sync2 #(
        .WIDTH       (1),
        .RESET_VALUE (1'b0)
    ) u_rst_sync (
        .i_clk   (i_clk_sys),
        .i_rstn  (i_rstn),
        .i_async (1'b1),
        .o_sync  (rst_sync_n)
    );

    // idle-high reset keeps a false START from appearing at release
    sync2 #(
        .WIDTH       (2),
        .RESET_VALUE (2'b11)
    ) u_pin_sync (
        .i_clk   (i_clk_sys),
        .i_rstn  (rst_sync_n),
        .i_async ({i_scl, i_sda}),
        .o_sync  (pins_raw)
    );

    assign pins_sync  = bus_pins_t'(pins_raw);
    assign scl_rise   = pins_sync.scl & ~pins_prev_reg.scl;
    assign scl_fall   = ~pins_sync.scl & pins_prev_reg.scl;
    assign start_seen = pins_sync.scl & pins_prev_reg.scl & pins_prev_reg.sda & ~pins_sync.sda;
    assign stop_seen  = pins_sync.scl & pins_prev_reg.scl & ~pins_prev_reg.sda & pins_sync.sda;
    assign timed_out  = (tmo_cnt_reg == TIMEOUT_LIMIT) & ~regs_reg.timeout_disable;

    function automatic logic [7:0] read_reg(input cfg_regs_t r, input logic [7:0] a);
        case (a)
            ADDR_BUS_TIMEOUT_CONFIG:  read_reg = {CFG_RESERVED_VALUE, r.timeout_disable};
            ADDR_LED_MODE_SELECT:     read_reg = {4'h0, r.led_mode};
            ADDR_PORT_DIRECTION_LOW:  read_reg = r.direction[7:0];
            ADDR_PORT_DIRECTION_HIGH: read_reg = r.direction[15:8];
            ADDR_DRIVE_TYPE_LOW:      read_reg = r.drive_type[7:0];
            ADDR_DRIVE_TYPE_HIGH:     read_reg = {4'h0, r.drive_type[11:8]};
            ADDR_SUPPLY_SELECT_LOW:   read_reg = r.supply[7:0];
            ADDR_SUPPLY_SELECT_HIGH:  read_reg = r.supply[15:8];
            default:                  read_reg = 8'h00;
        endcase
    endfunction

    function automatic cfg_regs_t write_reg(input cfg_regs_t r, input logic [7:0] a,
                                            input logic [7:0] d);
        cfg_regs_t w;
        w = r;
        case (a)
            ADDR_BUS_TIMEOUT_CONFIG:  w.timeout_disable = d[TIMEOUT_DISABLE_BIT];
            ADDR_LED_MODE_SELECT:     w.led_mode = d[3:0];
            ADDR_PORT_DIRECTION_LOW:  w.direction[7:0] = d;
            ADDR_PORT_DIRECTION_HIGH: w.direction[15:8] = d;
            ADDR_DRIVE_TYPE_LOW:      w.drive_type[7:0] = d;
            ADDR_DRIVE_TYPE_HIGH:     w.drive_type[11:8] = d[3:0];
            ADDR_SUPPLY_SELECT_LOW:   w.supply[7:0] = d;
            ADDR_SUPPLY_SELECT_HIGH:  w.supply[15:8] = d;
            default:                  w = r;
        endcase
        return w;
    endfunction

    function automatic logic [7:0] ptr_inc(input logic [7:0] p);
        if (p >= PTR_AUTOINC_FIRST && p < PTR_AUTOINC_LAST) begin
            ptr_inc = p + 8'h01;
        end else begin
            ptr_inc = p;
        end
    endfunction

    assign rd_byte = read_reg(regs_reg, ptr_reg);

    always_comb begin
        state_next   = state_reg;
        after_next   = after_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next   = shift_reg;
        ptr_next     = ptr_reg;
        sda_oe_next  = sda_oe_reg;
        regs_next    = regs_reg;
        tmo_cnt_next = tmo_cnt_reg;
        if (state_reg == S_IDLE || scl_rise || scl_fall) begin
            tmo_cnt_next = '0;
        end else if (tmo_cnt_reg != TIMEOUT_LIMIT) begin
            tmo_cnt_next = tmo_cnt_reg + TIMEOUT_CNT_W'(1);
        end
        if (start_seen) begin
            state_next   = S_ADDR;
            bit_cnt_next = 4'h0;
            sda_oe_next  = 1'b0;
        end else if (stop_seen || timed_out) begin
            state_next  = S_IDLE;
            sda_oe_next = 1'b0;
        end else if (scl_rise) begin
            case (state_reg)
                S_ADDR, S_CMD, S_WDATA: begin
                    shift_next   = {shift_reg[6:0], pins_sync.sda};
                    bit_cnt_next = bit_cnt_reg + 4'h1;
                end
                S_RDATA: bit_cnt_next = bit_cnt_reg + 4'h1;
                S_MACK:  bit_cnt_next = {3'h0, ~pins_sync.sda};
                default: bit_cnt_next = bit_cnt_reg;
            endcase
        end else if (scl_fall) begin
            case (state_reg)
                S_ADDR: begin
                    if (bit_cnt_reg == 4'h8) begin
                        if (shift_reg[7:1] == SLAVE_ADDR) begin
                            sda_oe_next = 1'b1;
                            after_next  = shift_reg[0] ? S_RDATA : S_CMD;
                            state_next  = S_ACK;
                        end else begin
                            state_next = S_IDLE;
                        end
                    end
                end
                S_CMD: begin
                    if (bit_cnt_reg == 4'h8) begin
                        ptr_next    = shift_reg;
                        sda_oe_next = 1'b1;
                        after_next  = S_WDATA;
                        state_next  = S_ACK;
                    end
                end
                S_WDATA: begin
                    if (bit_cnt_reg == 4'h8) begin
                        regs_next   = write_reg(regs_reg, ptr_reg, shift_reg);
                        ptr_next    = ptr_inc(ptr_reg);
                        sda_oe_next = 1'b1;
                        after_next  = S_WDATA;
                        state_next  = S_ACK;
                    end
                end
                S_ACK: begin
                    bit_cnt_next = 4'h0;
                    state_next   = after_reg;
                    if (after_reg == S_RDATA) begin
                        shift_next  = rd_byte;
                        ptr_next    = ptr_inc(ptr_reg);
                        sda_oe_next = ~rd_byte[7];
                    end else begin
                        sda_oe_next = 1'b0;
                    end
                end
                S_RDATA: begin
                    if (bit_cnt_reg == 4'h8) begin
                        sda_oe_next  = 1'b0;
                        bit_cnt_next = 4'h0;
                        state_next   = S_MACK;
                    end else begin
                        shift_next  = {shift_reg[6:0], 1'b0};
                        sda_oe_next = ~shift_reg[6];
                    end
                end
                S_MACK: begin
                    bit_cnt_next = 4'h0;
                    if (bit_cnt_reg == 4'h1) begin
                        shift_next  = rd_byte;
                        ptr_next    = ptr_inc(ptr_reg);
                        sda_oe_next = ~rd_byte[7];
                        state_next  = S_RDATA;
                    end else begin
                        state_next = S_IDLE;
                    end
                end
                default: state_next = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pins_prev_reg <= '{scl: 1'b1, sda: 1'b1};
            state_reg     <= S_IDLE;
            after_reg     <= S_IDLE;
            bit_cnt_reg   <= 4'h0;
            shift_reg     <= 8'h00;
            ptr_reg       <= 8'h00;
            sda_oe_reg    <= 1'b0;
            tmo_cnt_reg   <= '0;
            regs_reg      <= REGS_RESET;
        end else begin
            pins_prev_reg <= pins_sync;
            state_reg     <= state_next;
            after_reg     <= after_next;
            bit_cnt_reg   <= bit_cnt_next;
            shift_reg     <= shift_next;
            ptr_reg       <= ptr_next;
            sda_oe_reg    <= sda_oe_next;
            tmo_cnt_reg   <= tmo_cnt_next;
            regs_reg      <= regs_next;
        end
    end

    // open-drain data line: only ever pulls low
    assign o_sda_out         = 1'b0;
    assign o_sda_oe          = sda_oe_reg;
    assign o_timeout_disable = regs_reg.timeout_disable;

    assign o_port_ctrl.output_dir  = regs_reg.direction;
    assign o_port_ctrl.alt_supply  = regs_reg.supply;
    assign o_port_ctrl.led_sink_en = regs_reg.led_mode;
    assign o_port_ctrl.push_pull   = {4'h0, regs_reg.drive_type};
endmodule

// [verif/gpio_cfg_chk.sv]
`timescale 1ns/1ps
module gpio_cfg_chk
    import gpio_cfg_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rstn,
    input  wire logic       i_scl,
    input  wire logic       o_sda_out,
    input  wire logic       o_sda_oe,
    input  wire port_ctrl_t o_port_ctrl,
    input  wire logic       o_timeout_disable
);
    logic                     scl_reg;
    logic                     scl_next;
    logic [TIMEOUT_CNT_W-1:0] still_reg;
    logic [TIMEOUT_CNT_W-1:0] still_next;

    // cycles since the last clock-line edge, saturating
    always_comb begin
        scl_next   = i_scl;
        still_next = still_reg;
        if (i_scl != scl_reg) begin
            still_next = '0;
        end else if (still_reg != '1) begin
            still_next = still_reg + TIMEOUT_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            scl_reg   <= 1'b1;
            still_reg <= '0;
        end else begin
            scl_reg   <= scl_next;
            still_reg <= still_next;
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    property p_pp_fixed;
        o_port_ctrl.push_pull[15:12] == 4'h0;
    endproperty
    a_pp_fixed: assert property (p_pp_fixed)
        else $error("push-pull set on an led-capable pin");

    property p_sda_low;
        o_sda_out == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low)
        else $error("data pin output value not low");

    property p_ctl_fall;
        $changed(o_port_ctrl) |-> !i_scl && !$past(i_scl);
    endproperty
    a_ctl_fall: assert property (p_ctl_fall)
        else $error("port controls changed outside a clock-low phase");

    property p_td_fall;
        $changed(o_timeout_disable) |-> !i_scl && !$past(i_scl);
    endproperty
    a_td_fall: assert property (p_td_fall)
        else $error("timeout control changed outside a clock-low phase");

    property p_oe_edge;
        $changed(o_sda_oe) |-> !i_scl && !$past(i_scl);
    endproperty
    a_oe_edge: assert property (p_oe_edge)
        else $error("data drive changed while clock high");

    property p_oe_stand;
        $rose(o_sda_oe) |=> o_sda_oe [*8];
    endproperty
    a_oe_stand: assert property (p_oe_stand)
        else $error("data drive released too early");

    property p_tmo_drop;
        (still_reg >= TIMEOUT_CYCLES + 16) && !o_timeout_disable |-> !o_sda_oe;
    endproperty
    a_tmo_drop: assert property (p_tmo_drop)
        else $error("data pin still driven after clock stall");

    property p_tmo_hold;
        (still_reg > TIMEOUT_CNT_W'(8)) && !i_scl && o_timeout_disable && $past(o_sda_oe)
            |-> o_sda_oe;
    endproperty
    a_tmo_hold: assert property (p_tmo_hold)
        else $error("data drive dropped with timeout disabled");
endmodule

bind gpio_port_config_registers gpio_cfg_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
    .i_clk_sys         (i_clk_sys),
    .i_rstn            (i_rstn),
    .i_scl             (i_scl),
    .o_sda_out         (o_sda_out),
    .o_sda_oe          (o_sda_oe),
    .o_port_ctrl       (o_port_ctrl),
    .o_timeout_disable (o_timeout_disable)
);

// [verif/i2c_host_model.sv]
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic i_clk_sys,
    input  wire logic i_sda_oe,
    output logic      o_scl,
    output logic      o_sda
);
    logic sda_m;

    // wired-and data line with pull-up
    assign o_sda = sda_m & ~i_sda_oe;

    initial begin
        o_scl = 1'b1;
        sda_m = 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask

    // one bit: 160 ns period, sample at mid-high
    task automatic xfer(input logic b, input int pre, output logic s);
        sda_m <= b;
        cyc(pre);
        o_scl <= 1'b1;
        cyc(10);
        s = o_sda;
        cyc(10);
        o_scl <= 1'b0;
        cyc(10);
    endtask

    task automatic start();
        sda_m <= 1'b1;
        cyc(5);
        o_scl <= 1'b1;
        cyc(10);
        sda_m <= 1'b0;
        cyc(10);
        o_scl <= 1'b0;
        cyc(5);
    endtask

    task automatic stop();
        sda_m <= 1'b0;
        cyc(5);
        o_scl <= 1'b1;
        cyc(10);
        sda_m <= 1'b1;
        cyc(10);
    endtask

    task automatic put(input logic [7:0] d, input int stall, output logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(d[i], 10, s);
        xfer(1'b1, 10 + stall, nack);
    endtask

    task automatic get(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) xfer(1'b1, 10, d[i]);
        xfer(last, 10, s);
    endtask
endmodule

// [verif/tb_gpio_port_config_registers.sv]
`timescale 1ns/1ps
module tb_gpio_port_config_registers
    import gpio_cfg_pkg::*;
();
    localparam int TMO = 200;
    logic       i_clk_sys;
    logic       i_rstn;
    logic       scl;
    logic       sda;
    logic       sda_oe;
    logic       sda_out;
    logic       tdis;
    port_ctrl_t ctl;
    logic       nk;
    int         n_mismatch;
    int         tests_run;
    logic [7:0] wbuf [9];
    logic [7:0] ebuf [9];

    initial begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end

    gpio_port_config_registers #(.SLAVE_ADDR(SLAVE_ADDR_DEFAULT), .TIMEOUT_CYCLES(TMO)) u_dut (
        .i_clk_sys         (i_clk_sys),
        .i_rstn            (i_rstn),
        .i_scl             (scl),
        .i_sda             (sda),
        .o_sda_out         (sda_out),
        .o_sda_oe          (sda_oe),
        .o_port_ctrl       (ctl),
        .o_timeout_disable (tdis)
    );

    i2c_host_model u_host (
        .i_clk_sys (i_clk_sys),
        .i_sda_oe  (sda_oe),
        .o_scl     (scl),
        .o_sda     (sda)
    );

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] cmd, input int n,
                      input int stall, output logic nack_any);
        logic a;
        u_host.start();
        u_host.put(adr, 0, nack_any);
        u_host.put(cmd, stall, a);
        nack_any |= a;
        for (int i = 0; i < n; i++) begin
            u_host.put(wbuf[i], 0, a);
            nack_any |= a;
        end
        u_host.stop();
    endtask

    task automatic rd(input logic [7:0] cmd, input int n, input string what);
        logic       a;
        logic [7:0] d;
        u_host.start();
        u_host.put({SLAVE_ADDR_DEFAULT, 1'b0}, 0, a);
        u_host.put(cmd, 0, a);
        u_host.start();
        u_host.put({SLAVE_ADDR_DEFAULT, 1'b1}, 0, a);
        for (int i = 0; i < n; i++) begin
            u_host.get(i == n - 1, d);
            check(what, d, ebuf[i]);
        end
        u_host.stop();
    endtask

    initial begin
        i_rstn = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (4) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        check("reset ctl", ctl, 64'h0);
        check("reset tdis", tdis, 64'h0);
        check("sda out", sda_out, 64'h0);
        ebuf = '{default: 8'h00};
        rd(8'h31, 9, "reset regs");
        ebuf[0] = 8'h0A;
        rd(ADDR_BUS_TIMEOUT_CONFIG, 1, "config reset");
        wbuf = '{8'hF5, 8'h11, 8'h22, 8'hA1, 8'h5C, 8'h96, 8'hFB, 8'h3C, 8'hC3};
        wr(8'h40, ADDR_LED_MODE_SELECT, 9, 0, nk);
        check("burst ack", nk, 64'h0);
        check("dir", ctl.output_dir, 64'h5CA1);
        check("drive", ctl.push_pull, 64'h0B96);
        check("drive low", ctl.push_pull[7:0], 64'h96);
        check("supply", ctl.alt_supply, 64'hC33C);
        check("led", ctl.led_sink_en, 64'h5);
        ebuf = '{8'h05, 8'h00, 8'h00, 8'hA1, 8'h5C, 8'h96, 8'h0B, 8'h3C, 8'hC3};
        rd(ADDR_LED_MODE_SELECT, 9, "burst readback");
        wbuf[0] = 8'h00;
        wr(8'h42, ADDR_PORT_DIRECTION_LOW, 1, 0, nk);
        check("foreign nack", nk, 64'h1);
        wr(8'h40, ADDR_PORT_DIRECTION_LOW, 1, TMO + 50, nk);
        check("stall nack", nk, 64'h1);
        check("stall dir", ctl.output_dir, 64'h5CA1);
        wbuf[0] = 8'h01;
        wr(8'h40, ADDR_BUS_TIMEOUT_CONFIG, 1, 0, nk);
        check("tdis set", tdis, 64'h1);
        wbuf[0] = 8'h00;
        wr(8'h40, ADDR_PORT_DIRECTION_LOW, 1, TMO + 50, nk);
        check("no-timeout ack", nk, 64'h0);
        check("no-timeout dir", ctl.output_dir, 64'h5C00);
        ebuf[0] = 8'h0B;
        rd(ADDR_BUS_TIMEOUT_CONFIG, 1, "config set");
        i_rstn <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        check("rereset ctl", ctl, 64'h0);
        check("rereset tdis", tdis, 64'h0);
        i_rstn <= 1'b1;
        repeat (8) @(posedge i_clk_sys);
        ebuf[0] = 8'h0A;
        rd(ADDR_BUS_TIMEOUT_CONFIG, 1, "rereset config");
        tally_and_finish();
    end
endmodule
